// file: tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_OFS_CTRL     8'h00
`define TCC_OFS_SLAVE    8'h04
`define TCC_OFS_IEN      8'h08
`define TCC_OFS_FLAGS    8'h0C
`define TCC_OFS_EVGEN    8'h10
`define TCC_OFS_OUTEN    8'h14
`define TCC_OFS_CNT      8'h18
`define TCC_OFS_RELOAD   8'h1C
`define TCC_OFS_DTCFG    8'h20
`define TCC_OFS_CHVAL    4'h3
`define TCC_OFS_CHCFG    4'h4
`define TCC_RST_RELOAD   16'hFFFF
`define TCC_CTL_RUN      0
`define TCC_CTL_RELOAD_PRELOAD_ENABLE     7
`define TCC_IEN_DMA      8
`define TCC_FLG_OVF      8
`define TCC_DT_RUNOFF    10
`define TCC_DT_IDLEOFF   11
`define TCC_DT_GATE      15
`define TCC_DT_IDLE_M    16
`define TCC_DT_IDLE_C    20
`define TCC_TS_IN1       3'h5
`define TCC_TS_IN2       3'h6
`define TCC_SMS_RESET    3'h4
`endif

// file: tcc_pkg.sv
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_OM_FROZEN = 3'b000, TCC_OM_SET_HI = 3'b001, TCC_OM_SET_LO = 3'b010,
    TCC_OM_TOGGLE = 3'b011, TCC_OM_FORCE_LO = 3'b100, TCC_OM_FORCE_HI = 3'b101,
    TCC_OM_PWM1 = 3'b110, TCC_OM_PWM2 = 3'b111
  } tcc_omode_t;
  typedef enum logic [1:0] {
    TCC_DIR_OUT = 2'b00, TCC_DIR_OWN = 2'b01, TCC_DIR_NEIGH = 2'b10, TCC_DIR_RSVD = 2'b11
  } tcc_dir_t;
  typedef enum logic {TCC_CNT_DOWN = 1'b0, TCC_CNT_UP = 1'b1} tcc_cdir_t;
endpackage

// file: tcc_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_filter (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       din,
  input  wire logic [3:0] setting,
  output logic            filt
);
  logic [6:0] div_reg;
  logic [2:0] agree_reg;
  wire        tick   = (div_reg & ((7'h01 << setting[3:2]) - 7'h01)) == 7'h00;
  wire  [2:0] need   = {setting[1:0], 1'b1};
  // only a run of matching samples moves the output; noise shorter than that is lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_reg   <= 7'h00;
      agree_reg <= 3'h0;
      filt      <= 1'b0;
    end else begin
      div_reg <= div_reg + 7'h01;
      if (setting == 4'h0) begin
        filt <= din;
      end else if (tick) begin
        if (din == filt) begin
          agree_reg <= 3'h0;
        end else if (agree_reg >= need - 3'h1) begin
          filt      <= din;
          agree_reg <= 3'h0;
        end else begin
          agree_reg <= agree_reg + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tcc_deadtime.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_deadtime (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       ref_i,
  input  wire logic [9:0] dt,
  output logic            main_o,
  output logic            comp_o
);
  logic       ref_d_reg;
  logic [9:0] age_reg;
  wire        ripe    = ({1'b0, age_reg} + 11'h001) >= {1'b0, dt};
  // the change cycle itself passes only when no dead time is asked for
  wire        settled = (ref_i == ref_d_reg) ? ripe : (dt == 10'h000);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_d_reg <= 1'b0;
      age_reg   <= 10'h000;
      main_o    <= 1'b0;
      comp_o    <= 1'b0;
    end else begin
      ref_d_reg <= ref_i;
      age_reg   <= (ref_i != ref_d_reg) ? 10'h000 : (age_reg == 10'h3FF) ? age_reg : age_reg + 10'h001;
      main_o    <= ref_i & settled;
      comp_o    <= ~ref_i & settled;
    end
  end
  // a pulse shorter than the dead time never reaches the delayed output
  AST_DT_RISE_DELAY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(ref_i) && dt >= 10'h002 |=> !main_o ##1 !main_o) else $error("main output rose early");
endmodule
`default_nettype wire

// file: tcc_top.sv
// Behaviour
// - selected edge latches counter, sets match flag
// - capture while flag set raises overcapture
// - flag clears by write or read; overcapture write
// - flag set raises irq and dma if enabled
// - event generation write makes capture event
// - direction field: out, own, neighbour input
// - filter needs consistent samples to change
// - polarity picks rising or falling edge
// - prescaler divides edges; 00 every edge
// - edge capture only while channel enable set; event write captures regardless
// - compare match sets flag, drives reference
// - modes 100/101 force reference low/high
// - forced mode still compares and flags
// - pwm input: ch1 period, ch2 high time
// - modes 110/111 are pwm 1 and 2
// - preload moves to shadow on update
// - pwm1 high above register, low below
// - alignment select: edge or centre counting
// - ch1-3 main plus complementary, ch4 single
// - separate polarity, enable, gate, idle states
// - 10-bit dead time generator on ch1-3, one shared value
// - captures to shadow and preload, compares shadow
//
// Implementation choices: the address map and the APB slave port.
`include "tcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [3:0]  CH_IN,
  output logic      [3:0]  MAIN_OUT,
  output logic      [3:0]  MAIN_OE,
  output logic      [2:0]  COMP_OUT,
  output logic      [2:0]  COMP_OE,
  output logic      [3:0]  CHAN_IRQ,
  output logic      [3:0]  CHAN_DMA
);
  import tcc_pkg::*;

  logic [15:0] ctrl_reg;
  logic [6:0]  slave_reg;
  logic [15:0] ien_reg;
  logic [3:0]  flag_reg;
  logic [3:0]  ovf_reg;
  logic [15:0] outen_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        up_reg;
  logic        up_next;
  logic        upd;
  logic        moved_reg;
  logic [15:0] reload_reg;
  logic [15:0] reload_act_reg;
  logic [23:0] dtcfg_reg;
  logic [11:0] chcfg_reg [4];
  logic [15:0] preload_reg [4];
  logic [15:0] shadow_reg [4];
  logic [2:0]  pscnt_reg [4];
  logic [3:0]  sig_prev_reg;
  logic        trig_prev_reg;
  logic [3:0]  ref_reg;
  logic [3:0]  filt;
  logic [3:0]  dt_main;
  logic [2:0]  dt_comp;
  logic [31:0] rdata;

  // apb decode; a transfer completes with no wait state
  wire        setup   = PSEL & ~PENABLE;
  wire        acc     = PSEL & PENABLE & PREADY;
  wire        wr      = acc & PWRITE;
  wire        rd      = acc & ~PWRITE;
  wire        is_chv  = PADDR[7:4] == `TCC_OFS_CHVAL;
  wire        is_chc  = PADDR[7:4] == `TCC_OFS_CHCFG;
  wire [1:0]  pch     = PADDR[3:2];
  wire        wr_ctrl = wr & (PADDR == `TCC_OFS_CTRL);
  wire        wr_slv  = wr & (PADDR == `TCC_OFS_SLAVE);
  wire        wr_ien  = wr & (PADDR == `TCC_OFS_IEN);
  wire        wr_flg  = wr & (PADDR == `TCC_OFS_FLAGS);
  wire        wr_evg  = wr & (PADDR == `TCC_OFS_EVGEN);
  wire        wr_oen  = wr & (PADDR == `TCC_OFS_OUTEN);
  wire        wr_rld  = wr & (PADDR == `TCC_OFS_RELOAD);
  wire        wr_dt   = wr & (PADDR == `TCC_OFS_DTCFG);
  wire        mapped  = (PADDR <= `TCC_OFS_DTCFG) | is_chv | is_chc;
  wire        sw_upd  = wr_evg & PWDATA[0];
  wire        run     = ctrl_reg[`TCC_CTL_RUN];
  wire [1:0]  align   = ctrl_reg[6:5];
  wire        gate    = dtcfg_reg[`TCC_DT_GATE];

  // per-channel event wires
  logic [3:0] cap_evt;
  logic [3:0] match_evt;
  logic [3:0] set_evt;
  logic [3:0] rd_val;
  logic [3:0] sw_gen;
  logic [3:0] sig_sel;
  logic [3:0] hw_edge;

  // slave reset trigger from the filtered, polarised input 1 or input 2
  wire input1_filtered_edge_a = filt[0] ^ outen_reg[1];
  wire input2_filtered_edge_b = filt[1] ^ outen_reg[5];
  wire trig_sig = (slave_reg[6:4] == `TCC_TS_IN1) ? input1_filtered_edge_a :
                  (slave_reg[6:4] == `TCC_TS_IN2) ? input2_filtered_edge_b : 1'b0;
  wire trig_rst = (slave_reg[2:0] == `TCC_SMS_RESET) & trig_sig & ~trig_prev_reg;

  always_comb begin
    cnt_next = cnt_reg;
    up_next  = up_reg;
    upd      = 1'b0;
    if (sw_upd | trig_rst) begin
      cnt_next = 16'h0000;
      up_next  = TCC_CNT_UP;
      upd      = 1'b1;
    end else if (run) begin
      if (align == 2'b00) begin
        upd      = cnt_reg >= reload_act_reg;
        cnt_next = upd ? 16'h0000 : cnt_reg + 16'h0001;
      end else if (up_reg == TCC_CNT_UP) begin
        up_next  = (cnt_reg + 16'h0001 >= reload_act_reg) ? TCC_CNT_DOWN : TCC_CNT_UP;
        cnt_next = cnt_reg + 16'h0001;
      end else begin
        upd      = cnt_reg == 16'h0001;
        up_next  = upd ? TCC_CNT_UP : TCC_CNT_DOWN;
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg        <= 16'h0000;
      up_reg         <= TCC_CNT_UP;
      moved_reg      <= 1'b0;
      reload_act_reg <= `TCC_RST_RELOAD;
      trig_prev_reg  <= 1'b0;
    end else begin
      cnt_reg       <= cnt_next;
      up_reg        <= up_next;
      moved_reg     <= cnt_next != cnt_reg;
      trig_prev_reg <= trig_sig;
      if (upd | ~ctrl_reg[`TCC_CTL_RELOAD_PRELOAD_ENABLE]) begin
        reload_act_reg <= reload_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg   <= 16'h0000;
      slave_reg  <= 7'h00;
      ien_reg    <= 16'h0000;
      outen_reg  <= 16'h0000;
      reload_reg <= `TCC_RST_RELOAD;
      dtcfg_reg  <= 24'h000000;
    end else begin
      if (wr_ctrl) ctrl_reg <= PWDATA[15:0];
      if (wr_slv) slave_reg <= PWDATA[6:0];
      if (wr_ien) ien_reg <= PWDATA[15:0];
      if (wr_oen) outen_reg <= PWDATA[15:0];
      if (wr_rld) reload_reg <= PWDATA[15:0];
      if (wr_dt) dtcfg_reg <= PWDATA[23:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_ch
      wire [1:0]  dsel   = chcfg_reg[c][1:0];
      wire [1:0]  psc    = chcfg_reg[c][3:2];
      wire [2:0]  omode  = chcfg_reg[c][10:8];
      wire        pe     = chcfg_reg[c][11];
      wire        en_m   = outen_reg[4*c];
      wire        pol_m  = outen_reg[4*c+1];
      wire        is_in  = (dsel == TCC_DIR_OWN) | (dsel == TCC_DIR_NEIGH);
      wire [2:0]  pmask  = (psc == 2'b00) ? 3'h0 : (psc == 2'b01) ? 3'h1 :
                           (psc == 2'b10) ? 3'h3 : 3'h7;
      wire        pwm_hi = cnt_reg > shadow_reg[c];
      logic       ref_next;

      tcc_filter u_filt (
        .clk_sys (CLK_SYS),
        .arst_n  (ARST_N),
        .din     (CH_IN[c]),
        .setting (chcfg_reg[c][7:4]),
        .filt    (filt[c])
      );

      assign sig_sel[c]   = ((dsel == TCC_DIR_NEIGH) ? filt[c^1] : filt[c]) ^ pol_m;
      assign hw_edge[c]   = is_in & sig_sel[c] & ~sig_prev_reg[c];
      assign sw_gen[c]    = wr_evg & PWDATA[c+1];
      assign cap_evt[c]   = is_in & ((hw_edge[c] & en_m & ((pscnt_reg[c] & pmask) == pmask))
                            | sw_gen[c]);
      assign match_evt[c] = ~is_in & ((moved_reg & (cnt_reg == shadow_reg[c])) | sw_gen[c]);
      assign set_evt[c]   = cap_evt[c] | match_evt[c];
      assign rd_val[c]    = rd & is_chv & (pch == 2'(c));

      always_comb begin
        case (omode)
          TCC_OM_FROZEN:   ref_next = ref_reg[c];
          TCC_OM_SET_HI:   ref_next = match_evt[c] | ref_reg[c];
          TCC_OM_SET_LO:   ref_next = ~match_evt[c] & ref_reg[c];
          TCC_OM_TOGGLE:   ref_next = match_evt[c] ^ ref_reg[c];
          TCC_OM_FORCE_LO: ref_next = 1'b0;
          TCC_OM_FORCE_HI: ref_next = 1'b1;
          TCC_OM_PWM1:     ref_next = pwm_hi;
          TCC_OM_PWM2:     ref_next = ~pwm_hi;
          default:         ref_next = 1'b0;
        endcase
      end

      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          chcfg_reg[c]    <= 12'h000;
          preload_reg[c]  <= 16'h0000;
          shadow_reg[c]   <= 16'h0000;
          pscnt_reg[c]    <= 3'h0;
          sig_prev_reg[c] <= 1'b0;
          ref_reg[c]      <= 1'b0;
          flag_reg[c]     <= 1'b0;
          ovf_reg[c]      <= 1'b0;
          CHAN_IRQ[c]     <= 1'b0;
          CHAN_DMA[c]     <= 1'b0;
        end else begin
          sig_prev_reg[c] <= sig_sel[c];
          ref_reg[c]      <= is_in ? 1'b0 : ref_next;
          if (wr & is_chc & (pch == 2'(c))) chcfg_reg[c] <= PWDATA[11:0];
          if (hw_edge[c] & en_m) pscnt_reg[c] <= pscnt_reg[c] + 3'h1;
          if (cap_evt[c]) begin
            shadow_reg[c]  <= cnt_reg;
            preload_reg[c] <= cnt_reg;
          end else begin
            if (wr & is_chv & (pch == 2'(c))) preload_reg[c] <= PWDATA[15:0];
            // with preload on, a mid-period write cannot glitch the waveform
            if (~is_in & (~pe | upd)) shadow_reg[c] <= preload_reg[c];
          end
          // a new event wins over a clear in the same cycle
          if (set_evt[c]) flag_reg[c] <= 1'b1;
          else if ((wr_flg & ~PWDATA[c+1]) | rd_val[c]) flag_reg[c] <= 1'b0;
          if (cap_evt[c] & flag_reg[c]) ovf_reg[c] <= 1'b1;
          else if (wr_flg & ~PWDATA[c+`TCC_FLG_OVF+1]) ovf_reg[c] <= 1'b0;
          CHAN_IRQ[c] <= (flag_reg[c] | set_evt[c]) & ien_reg[c+1];
          CHAN_DMA[c] <= set_evt[c] & ien_reg[c+`TCC_IEN_DMA+1];
        end
      end

      if (c < 3) begin : g_pair
        wire en_c  = outen_reg[4*c+2];
        wire pol_c = outen_reg[4*c+3];
        wire both  = en_m & en_c;
        tcc_deadtime u_dt (
          .clk_sys (CLK_SYS),
          .arst_n  (ARST_N),
          .ref_i   (ref_reg[c]),
          .dt      (dtcfg_reg[9:0]),
          .main_o  (dt_main[c]),
          .comp_o  (dt_comp[c])
        );
        wire m_raw = both ? dt_main[c] : ref_reg[c];
        wire c_raw = both ? dt_comp[c] : ~ref_reg[c];
        always_ff @(posedge CLK_SYS or negedge ARST_N) begin
          if (!ARST_N) begin
            MAIN_OUT[c] <= 1'b0;
            MAIN_OE[c]  <= 1'b0;
            COMP_OUT[c] <= 1'b0;
            COMP_OE[c]  <= 1'b0;
          end else if (gate) begin
            MAIN_OE[c]  <= ~is_in & (en_m | dtcfg_reg[`TCC_DT_RUNOFF]);
            MAIN_OUT[c] <= en_m ? m_raw ^ pol_m : pol_m;
            COMP_OE[c]  <= ~is_in & (en_c | dtcfg_reg[`TCC_DT_RUNOFF]);
            COMP_OUT[c] <= en_c ? c_raw ^ pol_c : pol_c;
          end else begin
            MAIN_OE[c]  <= ~is_in & en_m & dtcfg_reg[`TCC_DT_IDLEOFF];
            MAIN_OUT[c] <= dtcfg_reg[`TCC_DT_IDLE_M+c];
            COMP_OE[c]  <= ~is_in & en_c & dtcfg_reg[`TCC_DT_IDLEOFF];
            COMP_OUT[c] <= dtcfg_reg[`TCC_DT_IDLE_C+c];
          end
        end
      end else begin : g_single
        // the fourth channel has no complementary pin and no dead time
        assign dt_main[c] = 1'b0;
        always_ff @(posedge CLK_SYS or negedge ARST_N) begin
          if (!ARST_N) begin
            MAIN_OUT[c] <= 1'b0;
            MAIN_OE[c]  <= 1'b0;
          end else begin
            MAIN_OE[c]  <= ~is_in & (gate ? (en_m | dtcfg_reg[`TCC_DT_RUNOFF]) :
                           (en_m & dtcfg_reg[`TCC_DT_IDLEOFF]));
            MAIN_OUT[c] <= gate ? (en_m ? ref_reg[c] ^ pol_m : pol_m) : dtcfg_reg[`TCC_DT_IDLE_M+c];
          end
        end
      end
    end
  endgenerate

  assign rdata = (PADDR == `TCC_OFS_CTRL)   ? {16'h0000, ctrl_reg} :
                 (PADDR == `TCC_OFS_SLAVE)  ? {25'h0000000, slave_reg} :
                 (PADDR == `TCC_OFS_IEN)    ? {16'h0000, ien_reg} :
                 (PADDR == `TCC_OFS_FLAGS)  ? {19'h00000, ovf_reg, 4'h0, flag_reg, 1'b0} :
                 (PADDR == `TCC_OFS_OUTEN)  ? {16'h0000, outen_reg} :
                 (PADDR == `TCC_OFS_CNT)    ? {16'h0000, cnt_reg} :
                 (PADDR == `TCC_OFS_RELOAD) ? {16'h0000, reload_reg} :
                 (PADDR == `TCC_OFS_DTCFG)  ? {8'h00, dtcfg_reg} :
                 is_chv ? {16'h0000, preload_reg[pch]} :
                 is_chc ? {20'h00000, chcfg_reg[pch]} : 32'h00000000;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= setup ? rdata : PRDATA;
      PSLVERR <= setup & ~mapped;
    end
  end

  wire pwm_hi_0 = cnt_reg > shadow_reg[0];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  AST_CAPTURE_LATCH: assert property (cap_evt[0] |=> preload_reg[0] == $past(cnt_reg) && flag_reg[0])
    else $error("capture did not latch counter");
  AST_OVERCAPTURE: assert property (cap_evt[1] && flag_reg[1] |=> ovf_reg[1])
    else $error("overcapture not flagged");
  AST_READ_CLEAR: assert property (rd_val[0] && !set_evt[0] |=> !flag_reg[0])
    else $error("read did not clear flag");
  AST_DMA_PULSE: assert property (set_evt[0] && ien_reg[`TCC_IEN_DMA+1] |=> CHAN_DMA[0])
    else $error("dma request missing");
  AST_NO_CAP_DISABLED: assert property (hw_edge[0] && !outen_reg[0] && !sw_gen[0] && !wr
    |=> $stable(preload_reg[0])) else $error("capture while disabled");
  AST_FORCE_LOW: assert property (chcfg_reg[0][10:8] == TCC_OM_FORCE_LO && !cap_evt[0]
    |=> !ref_reg[0]) else $error("forced low not held");
  AST_FORCED_FLAGS: assert property (chcfg_reg[0][10:8] == TCC_OM_FORCE_LO && match_evt[0]
    |=> flag_reg[0] && !ref_reg[0]) else $error("forced mode lost match flag");
  AST_PWM1_LEVEL: assert property (chcfg_reg[0][10:8] == TCC_OM_PWM1 && chcfg_reg[0][1:0] == 2'b00
    && pwm_hi_0 |=> ref_reg[0]) else $error("pwm1 level wrong");
  AST_PRELOAD_HOLD: assert property (chcfg_reg[0][11] && chcfg_reg[0][1:0] == 2'b00 && !upd
    |=> $stable(shadow_reg[0])) else $error("shadow moved without update");
  AST_SLAVE_RESET: assert property (trig_rst |=> cnt_reg == 16'h0000)
    else $error("trigger did not reset counter");

  COV_OVERCAPTURE: cover property (cap_evt[0] && flag_reg[0]);
  COV_PWM_INPUT: cover property (trig_rst && cap_evt[0]);
  COV_CENTRE_TURN: cover property (align != 2'b00 && up_reg == TCC_CNT_UP ##1 up_reg == TCC_CNT_DOWN);
endmodule
`default_nettype wire

// file: tcc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
  input  wire logic       CLK_SYS,
  output logic      [3:0] CH_IN,
  input  wire logic [3:0] MAIN_OUT,
  input  wire logic [2:0] COMP_OUT,
  input  wire logic [3:0] CHAN_DMA
);
  int dma_cnt;
  initial begin
    CH_IN = 4'h0;
    dma_cnt = 0;
  end
  // dma is a one-cycle pulse, so every rising edge sample counts once
  always @(posedge CLK_SYS) begin
    if (CHAN_DMA[0] === 1'b1) begin
      dma_cnt <= dma_cnt + 1;
    end
  end
  task automatic set_in(input int ch, input logic v);
    @(posedge CLK_SYS);
    CH_IN[ch] <= v;
  endtask
  task automatic pwm_src(input int ch, input int hi, input int per, input int n);
    repeat (n) begin
      set_in(ch, 1'b1);
      repeat (hi - 1) @(posedge CLK_SYS);
      set_in(ch, 1'b0);
      repeat (per - hi - 1) @(posedge CLK_SYS);
    end
  endtask
  // whole periods only: the count is then independent of phase
  task automatic measure(input int n, output int mh, output int ch);
    mh = 0;
    ch = 0;
    repeat (n) begin
      @(posedge CLK_SYS);
      if (MAIN_OUT[0] === 1'b1) begin
        mh++;
      end
      if (COMP_OUT[0] === 1'b1) begin
        ch++;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_top_test;
  import tcc_pkg::*;
  logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, seed;
  logic [3:0]  ch_in, main_out, main_oe, chan_irq, chan_dma;
  logic [2:0]  comp_out, comp_oe;
  logic [3:0]  ccr;
  int          err_total, checks, c0, d0, mh, chh;
  tcc_omode_t  md [3];
  tcc_top tcc_top_inst (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CH_IN(ch_in), .MAIN_OUT(main_out),
    .MAIN_OE(main_oe), .COMP_OUT(comp_out), .COMP_OE(comp_oe),
    .CHAN_IRQ(chan_irq), .CHAN_DMA(chan_dma)
  );
  tcc_pins_model tcc_pins_model_inst (
    .CLK_SYS(clk_sys), .CH_IN(ch_in), .MAIN_OUT(main_out),
    .COMP_OUT(comp_out), .CHAN_DMA(chan_dma)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error %0t bus timeout", $time);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // only channel 0 bits: idle output channels may match at count zero
  task automatic fl();
    rd(8'h0C);
    rdv = rdv & 32'h0000_0202;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic drv(input logic v);
    tcc_pins_model_inst.set_in(0, v);
    cyc(6);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // reload 15, dead time 2, window of ten periods
  function automatic int exp_hi(input int c, input tcc_omode_t m, input logic cp);
    int h;
    h = 15 - c;
    if (m == TCC_OM_TOGGLE) begin
      return 70;
    end
    if ((m == TCC_OM_PWM2) ^ cp) begin
      h = 16 - h;
    end
    return 10 * (h - 2);
  endfunction
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    checks = 0;
    seed = 32'h0001_0E07;
    md = '{TCC_OM_TOGGLE, TCC_OM_PWM1, TCC_OM_PWM2};
    cyc(10);
    arst_n <= 1'b1;
    rd(8'h1C);
    chk(rdv, 32'h0000_FFFF);
    rd(8'h7C);
    chk({rdv[30:0], errv}, 32'h1);
    wr(8'h14, 32'h1);
    wr(8'h40, 32'h1);
    wr(8'h08, 32'h0000_0202);
    wr(8'h00, 32'h1);
    d0 = tcc_pins_model_inst.dma_cnt;
    rd(8'h18);
    c0 = rdv;
    drv(1'b1);
    fl();
    chk(rdv, 32'h2);
    chk(chan_irq[0], 1'b1);
    rd(8'h30);
    chk(rdv > c0 && rdv < c0 + 60, 1'b1);
    fl();
    chk(rdv, 32'h0);
    drv(1'b0);
    drv(1'b1);
    drv(1'b0);
    drv(1'b1);
    fl();
    chk(rdv, 32'h202);
    rd(8'h30);
    fl();
    chk(rdv, 32'h200);
    wr(8'h0C, 32'h0);
    fl();
    chk(rdv, 32'h0);
    chk(tcc_pins_model_inst.dma_cnt - d0, 3);
    wr(8'h14, 32'h3);
    drv(1'b0);
    fl();
    chk(rdv, 32'h2);
    wr(8'h0C, 32'h0);
    drv(1'b1);
    fl();
    chk(rdv, 32'h0);
    wr(8'h14, 32'h0);
    drv(1'b0);
    drv(1'b1);
    fl();
    chk(rdv, 32'h0);
    wr(8'h10, 32'h2);
    fl();
    chk(rdv, 32'h2);
    wr(8'h14, 32'h1);
    wr(8'h40, 32'h5);
    d0 = tcc_pins_model_inst.dma_cnt;
    repeat (4) begin
      drv(1'b0);
      drv(1'b1);
    end
    chk(tcc_pins_model_inst.dma_cnt - d0, 2);
    wr(8'h40, 32'h11);
    drv(1'b0);
    wr(8'h0C, 32'h0);
    tcc_pins_model_inst.set_in(0, 1'b1);
    drv(1'b0);
    fl();
    chk(rdv, 32'h0);
    drv(1'b1);
    fl();
    chk(rdv, 32'h2);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'h2);
    wr(8'h14, 32'h31);
    wr(8'h04, 32'h54);
    tcc_pins_model_inst.pwm_src(0, 7, 20, 4);
    rd(8'h30);
    c0 = rdv;
    rd(8'h34);
    chk(c0 - rdv, 32'd13);
    chk(c0 >= 19 && c0 <= 20, 1'b1);
    wr(8'h04, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h1C, 32'd15);
    wr(8'h20, 32'h8000);
    wr(8'h14, 32'h1);
    wr(8'h40, 32'h400);
    wr(8'h30, 32'd5);
    wr(8'h0C, 32'h0);
    cyc(40);
    fl();
    chk(rdv, 32'h2);
    chk({main_oe[0], main_out[0]}, 2'b10);
    wr(8'h40, 32'h100);
    cyc(20);
    chk(main_out[0], 1'b1);
    wr(8'h40, 32'h200);
    cyc(20);
    chk(main_out[0], 1'b0);
    wr(8'h40, 32'h500);
    cyc(4);
    chk(main_out[0], 1'b1);
    wr(8'h20, 32'h8002);
    wr(8'h14, 32'h5);
    foreach (md[i]) begin
      seed = xs(seed);
      ccr = 4'd3 + 4'(seed % 10);
      // pwm mode 1 goes through preload and update, mode 2 writes straight
      wr(8'h40, {20'h0, i == 1, md[i], 8'h0});
      wr(8'h30, {28'h0, ccr});
      wr(8'h10, 32'h1);
      cyc(40);
      tcc_pins_model_inst.measure(160, mh, chh);
      chk(mh, exp_hi(ccr, md[i], 1'b0));
      chk(chh, exp_hi(ccr, md[i], 1'b1));
    end
    // centre counting: 0 up to 15 and back to 1, thirty cycles a period
    wr(8'h00, 32'h21);
    wr(8'h10, 32'h1);
    cyc(40);
    tcc_pins_model_inst.measure(150, mh, chh);
    chk(mh, 5 * (2 * ccr - 1));
    chk(chh, 5 * (27 - 2 * ccr));
    wr(8'h20, 32'h2);
    cyc(4);
    chk({main_oe[0], comp_oe[0]}, 2'b00);
    summarize();
  end
endmodule
`default_nettype wire
